// File: design/i2c_cfg_pkg.sv
// package: register offsets, field positions, reset values and carrier types
package i2c_cfg_pkg;
  // ==========================================================
  // register offsets (register-file addresses)
  localparam logic [7:0] OFS_SCL_CLOCK_CONTROL = 8'hf3;
  localparam logic [7:0] OFS_OWN_ID_LOW = 8'hf4;
  localparam logic [7:0] OFS_OWN_ID_HIGH = 8'hf5;
  localparam logic [7:0] OFS_DATA_BYTE = 8'hf6;
  localparam logic [7:0] OFS_GENERAL_CALL_ID = 8'hf7;
  localparam logic [7:0] OFS_IRQ_PENDING = 8'hf8;
  localparam logic [7:0] OFS_IRQ_VECTOR = 8'hf9;
  localparam logic [7:0] OFS_RX_DMA_POINTER = 8'hfa;
  localparam logic [7:0] OFS_RX_DMA_COUNTER = 8'hfb;
  localparam logic [7:0] OFS_EXT_CLOCK_CONTROL = 8'hfe;
  // ==========================================================
  // field positions
  localparam int FAST_MODE_BIT = 7;
  localparam int TEN_BIT_MODE_BIT = 5;
  localparam int RANGE_HI_BIT = 4;
  localparam int DMA_STOP_BIT = 7;
  localparam int ERR_PEND_BIT = 2;
  localparam int RX_PEND_BIT = 1;
  localparam int TX_PEND_BIT = 0;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_GENERAL_CALL = 8'ha0;
  localparam logic [7:0] RST_IRQ_PENDING = 8'hf0;
  localparam logic [7:0] RST_UNDEF = 8'h00;
  localparam logic [7:0] IGNORED_ID = 8'h01;
  // ==========================================================
  // clock range codes and bus timing counts per range
  localparam logic [2:0] RANGE_2M5_6 = 3'h0;
  localparam logic [2:0] RANGE_6_10 = 3'h1;
  localparam logic [2:0] RANGE_10_14 = 3'h2;
  localparam logic [2:0] RANGE_14_24 = 3'h3;
  localparam logic [3:0] DELAY_2M5_6 = 4'h1;
  localparam logic [3:0] DELAY_6_10 = 4'h2;
  localparam logic [3:0] DELAY_10_14 = 4'h3;
  localparam logic [3:0] DELAY_14_24 = 4'h5;
  // ==========================================================
  // vector source codes
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_ERROR = 2'h1;
  localparam logic [1:0] SRC_RX = 2'h2;
  localparam logic [1:0] SRC_TX = 2'h3;
  // ==========================================================
  // carrier types
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic slave_match_flag;
    logic start_sent_flag;
    logic scl_flag;
    logic header_sent_flag;
    logic ack_failure_flag;
    logic stop_seen_flag;
    logic arbitration_lost_flag;
    logic bus_error_flag;
  } err_flags_t;
  typedef struct packed {
    logic fast_mode_select;
    logic [8:0] scl_divider;
    logic [2:0] clock_range_sel;
    logic [3:0] range_delay;
    logic ten_bit_mode;
    logic [9:0] own_id;
    logic own_id_valid;
    logic [6:0] general_call;
    logic general_call_valid;
  } bus_cfg_t;
  typedef struct packed {
    logic [6:0] rx_pointer_loc;
    logic rx_ext_select;
    logic [6:0] rx_count_pointer;
    logic dma_target_select;
  } rx_dma_cfg_t;
  typedef enum logic [2:0] {
    REQ_NONE,
    REQ_ERR_HI,
    REQ_RX_DMA,
    REQ_TX_DMA,
    REQ_ERR_LO,
    REQ_RX,
    REQ_TX
  } req_src_t;
endpackage : i2c_cfg_pkg

// File: design/i2c_range_decode.sv
// module: clock range code to bus timing delay count
`timescale 1ns/1ps
module i2c_range_decode
  import i2c_cfg_pkg::*;
(
  // range code
  input wire logic [2:0] range_in,
  // delay count
  output logic [3:0] delay_out
);
  // ==========================================================
  // forbidden codes fall back to the fastest (14-24) range scaling
  wire logic is_r0 = (range_in == RANGE_2M5_6);
  wire logic is_r1 = (range_in == RANGE_6_10);
  wire logic is_r2 = (range_in == RANGE_10_14);
  wire logic is_r3 = (range_in == RANGE_14_24);
  assign delay_out = is_r1 ? DELAY_6_10 : is_r2 ? DELAY_10_14 :
                     is_r3 ? DELAY_14_24 : is_r0 ? DELAY_2M5_6 : DELAY_14_24;
endmodule : i2c_range_decode

// File: design/i2c_req_rank.sv
// module: fixed ranking of internal interrupt and dma requests
`timescale 1ns/1ps
module i2c_req_rank
  import i2c_cfg_pkg::*;
(
  // request inputs
  input wire logic dma_stop_in,
  input wire logic err_in,
  input wire logic rx_dma_in,
  input wire logic tx_dma_in,
  input wire logic rx_in,
  input wire logic tx_in,
  // winner
  output req_src_t win_out
);
  // ==========================================================
  assign win_out = (err_in && dma_stop_in) ? REQ_ERR_HI :
                   rx_dma_in ? REQ_RX_DMA :
                   tx_dma_in ? REQ_TX_DMA :
                   err_in ? REQ_ERR_LO :
                   rx_in ? REQ_RX :
                   tx_in ? REQ_TX : REQ_NONE;
endmodule : i2c_req_rank

// File: design/i2c_config_irq_dma_regs.sv
// module: i2c configuration, addressing, data, interrupt and receive dma registers
`timescale 1ns/1ps
// Summary of operation
// - fast/standard mode bit is software written and kept while disabled.
// - nine-bit scl divider, low seven here, upper two in extended register; kept.
// - seven-bit own address is bits 7:1; bit 0 ignored; kept while disabled.
// - address 01h is never answered as general-call address, nor as own address in seven-bit mode.
// - ten-bit address: low register gives 7:0, high bits 2:1 give 9:8.
// - three-bit range field scales bus timing to internal clock range.
// - range field is writable only while the interface is disabled.
// - ten-bit mode bit selects addressing; writable only while disabled.
// - transmit sends data byte, starting on cpu write or dma completion.
// - receive holds last byte; next starts on cpu read or dma completion.
// - general-call register resets to a0h, locked while enabled, bit 0 ignored.
// - three-bit priority level, zero highest, seven meaning no priority.
// - requests ranked: error(stop), rx dma, tx dma, error, rx, tx.
// - pending bits clear on written zero; written one does nothing.
// - error pending forced high while any error flag is set.
// - rx and tx pending set on events only when global enable is set.
// - vector holds five base bits, two hardware source bits, bit 0 zero.
// - rx pointer bits 7:1 locate data pointer; bit 0 selects extension.
// - rx counter bits 7:1 locate counter, or address/counter pair.
// - rx counter bit 0 selects memory or register file destination.
// - rx dma enable clears when counter reaches zero, with end-of-block.
// - transfer event flags clear when the interface is disabled.
module i2c_config_irq_dma_regs
  import i2c_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // register-file access
  input wire i2c_cfg_pkg::reg_req_t req_in,
  output logic [7:0] rdata_out,
  // control from the rest of the interface
  input wire logic interface_enable_in,
  input wire logic irq_global_enable_in,
  input wire logic rx_dma_mask_in,
  input wire logic tx_dma_req_in,
  // bus engine events
  input wire i2c_cfg_pkg::err_flags_t err_flags_in,
  input wire logic rx_byte_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic tx_ready_in,
  input wire logic rx_dma_done_in,
  input wire logic tx_dma_done_in,
  input wire logic rx_count_zero_in,
  // configuration to the bus engine
  output i2c_cfg_pkg::bus_cfg_t bus_cfg_out,
  output i2c_cfg_pkg::rx_dma_cfg_t rx_dma_cfg_out,
  output logic [7:0] tx_byte_out,
  output logic tx_start_out,
  output logic rx_resume_out,
  // interrupt and dma request outputs
  output logic [2:0] priority_level_out,
  output logic irq_req_out,
  output logic rx_dma_req_out,
  output logic rx_dma_mask_clear_out,
  output logic rx_end_of_block_out,
  output logic [7:0] irq_vector_out,
  output logic event_flags_clear_out
);
  import i2c_cfg_pkg::*;

  // ==========================================================
  // register storage
  logic [7:0] clk_ctrl_reg;
  logic [1:0] clk_ext_reg;
  logic [7:0] own_low_reg;
  logic [7:0] own_high_reg;
  logic [7:0] data_byte_reg;
  logic [7:0] gen_call_reg;
  logic [7:0] pend_reg;
  logic [4:0] vec_base_reg;
  logic [7:0] rx_ptr_reg;
  logic [7:0] rx_cnt_reg;
  logic [7:0] rdata_reg;
  bus_cfg_t bus_cfg_reg;
  rx_dma_cfg_t rx_dma_cfg_reg;
  logic [7:0] tx_byte_reg;
  logic tx_start_reg;
  logic rx_resume_reg;
  logic [2:0] prio_reg;
  logic irq_reg;
  logic rx_dma_req_reg;
  logic mask_clr_reg;
  logic eob_reg;
  logic [7:0] vec_out_reg;
  logic ev_clr_reg;
  logic enable_d_reg;

  // ==========================================================
  // address decode
  wire logic wr_clk = req_in.wr && (req_in.addr == OFS_SCL_CLOCK_CONTROL);
  wire logic wr_ext = req_in.wr && (req_in.addr == OFS_EXT_CLOCK_CONTROL);
  wire logic wr_own_lo = req_in.wr && (req_in.addr == OFS_OWN_ID_LOW);
  wire logic wr_own_hi = req_in.wr && (req_in.addr == OFS_OWN_ID_HIGH);
  wire logic wr_data = req_in.wr && (req_in.addr == OFS_DATA_BYTE);
  wire logic rd_data = req_in.rd && (req_in.addr == OFS_DATA_BYTE);
  wire logic wr_gen = req_in.wr && (req_in.addr == OFS_GENERAL_CALL_ID);
  wire logic wr_pend = req_in.wr && (req_in.addr == OFS_IRQ_PENDING);
  wire logic wr_vec = req_in.wr && (req_in.addr == OFS_IRQ_VECTOR);
  wire logic wr_rx_ptr = req_in.wr && (req_in.addr == OFS_RX_DMA_POINTER);
  wire logic wr_rx_cnt = req_in.wr && (req_in.addr == OFS_RX_DMA_COUNTER);
  wire logic disabled = !interface_enable_in;

  // ==========================================================
  // configuration register next values
  // locked fields only move while the interface is off
  wire logic [7:0] own_hi_wmask = disabled ? 8'hf6 : 8'h06;
  wire logic [7:0] own_high_next = (req_in.wdata & own_hi_wmask) |
                                   (own_high_reg & ~own_hi_wmask & 8'hf6);
  wire logic [7:0] gen_call_next = (wr_gen && disabled) ? req_in.wdata : gen_call_reg;

  // ==========================================================
  // pending bits: hardware set wins over software clear
  wire logic [7:0] err_bits = err_flags_in;
  wire logic err_any = |err_bits;
  wire logic rx_set = rx_byte_valid_in && irq_global_enable_in;
  wire logic tx_set = tx_ready_in && irq_global_enable_in;
  wire logic err_set = err_any && irq_global_enable_in;
  wire logic [2:0] pend_clr = wr_pend ? ~req_in.wdata[2:0] : 3'h0;
  wire logic [2:0] pend_hw = {err_set, rx_set, tx_set};
  wire logic [2:0] pend_low_next = (pend_reg[2:0] & ~pend_clr) | pend_hw;
  wire logic [2:0] pend_force = {err_any, 2'h0};
  wire logic [7:0] pend_next = {
    wr_pend ? req_in.wdata[DMA_STOP_BIT] : pend_reg[DMA_STOP_BIT],
    wr_pend ? req_in.wdata[6:4] : pend_reg[6:4],
    1'b0,
    pend_low_next | pend_force
  };

  // ==========================================================
  // request ranking and vector source
  req_src_t win;
  i2c_req_rank u_rank (
    .dma_stop_in(pend_reg[DMA_STOP_BIT]),
    .err_in(pend_reg[ERR_PEND_BIT]),
    .rx_dma_in(rx_dma_mask_in && rx_byte_valid_in),
    .tx_dma_in(tx_dma_req_in),
    .rx_in(pend_reg[RX_PEND_BIT]),
    .tx_in(pend_reg[TX_PEND_BIT]),
    .win_out(win)
  );
  wire logic [1:0] src_code = (win == REQ_ERR_HI || win == REQ_ERR_LO) ? SRC_ERROR :
                              (win == REQ_RX) ? SRC_RX :
                              (win == REQ_TX) ? SRC_TX : SRC_NONE;
  // level 7 means no priority: nothing is raised
  wire logic prio_active = (pend_reg[6:4] != 3'h7);
  wire logic irq_next = prio_active && (win == REQ_ERR_HI || win == REQ_ERR_LO ||
                                        win == REQ_RX || win == REQ_TX);
  wire logic rx_dma_next = prio_active && (win == REQ_RX_DMA);

  // ==========================================================
  // address formation; 01h never answers as general call or as seven-bit own address
  wire logic [9:0] own_id = own_high_reg[TEN_BIT_MODE_BIT] ?
                            {own_high_reg[2:1], own_low_reg} :
                            {3'h0, own_low_reg[7:1]};
  wire logic own_valid = own_high_reg[TEN_BIT_MODE_BIT] || (own_low_reg != IGNORED_ID);
  wire logic gen_valid = (gen_call_reg != IGNORED_ID);
  wire logic [2:0] range_sel = {own_high_reg[RANGE_HI_BIT], own_high_reg[7:6]};
  logic [3:0] range_delay;
  i2c_range_decode u_range (
    .range_in(range_sel),
    .delay_out(range_delay)
  );
  bus_cfg_t bus_cfg_next;
  assign bus_cfg_next = '{
    fast_mode_select: clk_ctrl_reg[FAST_MODE_BIT],
    scl_divider: {clk_ext_reg, clk_ctrl_reg[6:0]},
    clock_range_sel: range_sel,
    range_delay: range_delay,
    ten_bit_mode: own_high_reg[TEN_BIT_MODE_BIT],
    own_id: own_id,
    own_id_valid: own_valid,
    general_call: gen_call_reg[7:1],
    general_call_valid: gen_valid
  };
  rx_dma_cfg_t rx_dma_cfg_next;
  assign rx_dma_cfg_next = '{
    rx_pointer_loc: rx_ptr_reg[7:1],
    rx_ext_select: rx_ptr_reg[0],
    rx_count_pointer: rx_cnt_reg[7:1],
    dma_target_select: rx_cnt_reg[0]
  };

  // ==========================================================
  // read data selection
  wire logic [7:0] vec_value = {vec_base_reg, src_code, 1'b0};
  wire logic [7:0] rd_mux =
    (req_in.addr == OFS_SCL_CLOCK_CONTROL) ? clk_ctrl_reg :
    (req_in.addr == OFS_EXT_CLOCK_CONTROL) ? {6'h00, clk_ext_reg} :
    (req_in.addr == OFS_OWN_ID_LOW) ? own_low_reg :
    (req_in.addr == OFS_OWN_ID_HIGH) ? own_high_reg :
    (req_in.addr == OFS_DATA_BYTE) ? data_byte_reg :
    (req_in.addr == OFS_GENERAL_CALL_ID) ? gen_call_reg :
    (req_in.addr == OFS_IRQ_PENDING) ? pend_reg :
    (req_in.addr == OFS_IRQ_VECTOR) ? vec_value :
    (req_in.addr == OFS_RX_DMA_POINTER) ? rx_ptr_reg :
    (req_in.addr == OFS_RX_DMA_COUNTER) ? rx_cnt_reg : 8'h00;

  // ==========================================================
  // data register: cpu write or received byte
  wire logic [7:0] data_next = wr_data ? req_in.wdata :
                               rx_byte_valid_in ? rx_byte_in : data_byte_reg;
  // disable edge clears transfer event flags in the engine
  wire logic ev_clr_next = enable_d_reg && disabled;
  wire logic eob_next = rx_dma_mask_in && rx_count_zero_in;

  // ==========================================================
  // configuration registers; cleared by reset only, not by disable
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      clk_ctrl_reg <= RST_ZERO;
      clk_ext_reg <= 2'h0;
      own_low_reg <= RST_ZERO;
      own_high_reg <= RST_ZERO;
      gen_call_reg <= RST_GENERAL_CALL;
      vec_base_reg <= 5'h00;
      rx_ptr_reg <= RST_UNDEF;
      rx_cnt_reg <= RST_UNDEF;
    end else begin
      if (wr_clk) clk_ctrl_reg <= req_in.wdata;
      if (wr_ext) clk_ext_reg <= req_in.wdata[1:0];
      if (wr_own_lo) own_low_reg <= req_in.wdata;
      if (wr_own_hi) own_high_reg <= own_high_next;
      gen_call_reg <= gen_call_next;
      if (wr_vec) vec_base_reg <= req_in.wdata[7:3];
      if (wr_rx_ptr) rx_ptr_reg <= req_in.wdata;
      if (wr_rx_cnt) rx_cnt_reg <= req_in.wdata;
    end
  end

  // ==========================================================
  // data, pending and enable delay
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      data_byte_reg <= RST_ZERO;
      pend_reg <= RST_IRQ_PENDING;
      enable_d_reg <= 1'b0;
    end else begin
      data_byte_reg <= data_next;
      pend_reg <= pend_next;
      enable_d_reg <= interface_enable_in;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= 8'h00;
      bus_cfg_reg <= '0;
      rx_dma_cfg_reg <= '0;
      tx_byte_reg <= 8'h00;
      tx_start_reg <= 1'b0;
      rx_resume_reg <= 1'b0;
      prio_reg <= 3'h7;
      irq_reg <= 1'b0;
      rx_dma_req_reg <= 1'b0;
      mask_clr_reg <= 1'b0;
      eob_reg <= 1'b0;
      vec_out_reg <= 8'h00;
      ev_clr_reg <= 1'b0;
    end else begin
      rdata_reg <= rd_mux;
      bus_cfg_reg <= bus_cfg_next;
      rx_dma_cfg_reg <= rx_dma_cfg_next;
      tx_byte_reg <= data_next;
      // dma completion restarts on the very next edge, no extra stage
      tx_start_reg <= wr_data || tx_dma_done_in;
      rx_resume_reg <= rd_data || rx_dma_done_in;
      prio_reg <= pend_reg[6:4];
      irq_reg <= irq_next;
      rx_dma_req_reg <= rx_dma_next;
      mask_clr_reg <= eob_next;
      eob_reg <= eob_next;
      vec_out_reg <= vec_value;
      ev_clr_reg <= ev_clr_next;
    end
  end

  // ==========================================================
  // output drive
  assign rdata_out = rdata_reg;
  assign bus_cfg_out = bus_cfg_reg;
  assign rx_dma_cfg_out = rx_dma_cfg_reg;
  assign tx_byte_out = tx_byte_reg;
  assign tx_start_out = tx_start_reg;
  assign rx_resume_out = rx_resume_reg;
  assign priority_level_out = prio_reg;
  assign irq_req_out = irq_reg;
  assign rx_dma_req_out = rx_dma_req_reg;
  assign rx_dma_mask_clear_out = mask_clr_reg;
  assign rx_end_of_block_out = eob_reg;
  assign irq_vector_out = vec_out_reg;
  assign event_flags_clear_out = ev_clr_reg;
endmodule : i2c_config_irq_dma_regs

// File: verification/i2c_engine_model.sv
// far-side bus engine model: raises transfer events and error flags on command
`timescale 1ns/1ps
module i2c_engine_model
(
  // clock
  input wire logic clk_in,
  // events toward the register block
  output i2c_cfg_pkg::err_flags_t err_flags_out,
  output logic rx_byte_valid_out,
  output logic [7:0] rx_byte_out,
  output logic tx_ready_out,
  output logic rx_dma_done_out,
  output logic tx_dma_done_out,
  output logic rx_count_zero_out
);
  import i2c_cfg_pkg::*;
  // ==========================================================
  // idle state
  initial begin
    err_flags_out = '0;
    {rx_count_zero_out, tx_dma_done_out, rx_dma_done_out, tx_ready_out, rx_byte_valid_out} = '0;
    rx_byte_out = 8'h5a;
  end
  // ==========================================================
  // one-cycle event: 0 rx byte, 1 tx ready, 2 rx dma done, 3 tx dma done, 4 count zero
  task automatic pulse(input int kind, input logic [7:0] data);
    @(posedge clk_in);
    rx_byte_out <= data;
    {rx_count_zero_out, tx_dma_done_out, rx_dma_done_out, tx_ready_out, rx_byte_valid_out} <=
      5'h01 << kind;
    @(posedge clk_in);
    {rx_count_zero_out, tx_dma_done_out, rx_dma_done_out, tx_ready_out, rx_byte_valid_out} <= '0;
    // stale byte must not look valid, so show its inverse
    rx_byte_out <= ~data;
  endtask : pulse
  // flags are levels, held until the next set_flags call
  task automatic set_flags(input err_flags_t f);
    @(posedge clk_in);
    err_flags_out <= f;
  endtask : set_flags
endmodule : i2c_engine_model

// File: verification/i2c_regs_props.sv
// concurrent assertions on the register block ports
`timescale 1ns/1ps
module i2c_regs_props
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // register access and events
  input wire i2c_cfg_pkg::reg_req_t req_in,
  input wire logic [7:0] rdata_out,
  input wire logic interface_enable_in,
  input wire logic rx_dma_mask_in,
  input wire logic tx_dma_req_in,
  input wire i2c_cfg_pkg::err_flags_t err_flags_in,
  input wire logic rx_byte_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_dma_done_in,
  input wire logic tx_dma_done_in,
  input wire logic rx_count_zero_in,
  // design outputs
  input wire i2c_cfg_pkg::bus_cfg_t bus_cfg_out,
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_start_out,
  input wire logic rx_resume_out,
  input wire logic [2:0] priority_level_out,
  input wire logic irq_req_out,
  input wire logic rx_dma_mask_clear_out,
  input wire logic rx_end_of_block_out,
  input wire logic [7:0] irq_vector_out,
  input wire logic event_flags_clear_out
);
  import i2c_cfg_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================================
  // helpers
  wire logic data_wr = req_in.wr && req_in.addr == OFS_DATA_BYTE;
  wire logic data_rd = req_in.rd && req_in.addr == OFS_DATA_BYTE;
  logic [7:0] wd1_reg;
  logic [7:0] wd2_reg;
  always_ff @(posedge clk_in) begin
    wd1_reg <= req_in.wdata;
    wd2_reg <= wd1_reg;
  end
  sequence s_rx_then_read;
    rx_byte_valid_in ##1 !rx_byte_valid_in ##1 data_rd;
  endsequence
  sequence s_cfg_write;
    req_in.wr && req_in.addr == OFS_OWN_ID_HIGH && !interface_enable_in;
  endsequence
  // ==========================================================
  // checks
  chk_tx_write_start: assert property (data_wr |=> tx_start_out && tx_byte_out == $past(req_in.wdata))
    else $error("transmit not started by data write");
  chk_tx_dma_start: assert property (tx_dma_done_in |=> tx_start_out)
    else $error("transmit not started after dma block");
  chk_rx_resume: assert property (data_rd || rx_dma_done_in |=> rx_resume_out)
    else $error("receive not resumed");
  chk_rx_byte_held: assert property (s_rx_then_read |=> rdata_out == $past(rx_byte_in, 3))
    else $error("received byte not held in data register");
  chk_mask_clear_eob: assert property (rx_count_zero_in && rx_dma_mask_in |=> rx_dma_mask_clear_out && rx_end_of_block_out)
    else $error("rx dma enable not cleared at count zero");
  chk_prio_quiet: assert property ((priority_level_out == 3'h7) [*2] |-> !irq_req_out)
    else $error("request raised at lowest level");
  chk_err_vector: assert property ((|err_flags_in && !tx_dma_req_in && !rx_dma_mask_in) [*3] |-> irq_vector_out[2:1] == SRC_ERROR)
    else $error("error source not shown while flags set");
  chk_disable_clear: assert property ($fell(interface_enable_in) |-> ##[0:2] event_flags_clear_out)
    else $error("event flags not cleared on disable");
  chk_cfg_update: assert property (s_cfg_write |=> ##1 bus_cfg_out.ten_bit_mode == wd2_reg[5] && bus_cfg_out.clock_range_sel == {wd2_reg[4], wd2_reg[7:6]})
    else $error("addressing or range setting not applied");
endmodule : i2c_regs_props
bind i2c_config_irq_dma_regs i2c_regs_props props (.*);

// File: verification/i2c_config_irq_dma_regs_test.sv
// self-checking bench for the i2c configuration, interrupt and rx dma registers
`timescale 1ns/1ps
module i2c_config_irq_dma_regs_test;
  import i2c_cfg_pkg::*;
  typedef struct {string name; logic [15:0] v;} note_t;
  // ==========================================================
  // signals
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  reg_req_t req_in = '0;
  logic interface_enable_in = 1'b0, irq_global_enable_in = 1'b0;
  logic rx_dma_mask_in = 1'b0, tx_dma_req_in = 1'b0;
  err_flags_t err_flags_in;
  logic rx_byte_valid_in, tx_ready_in, rx_dma_done_in, tx_dma_done_in, rx_count_zero_in;
  logic [7:0] rx_byte_in, rdata_out, tx_byte_out, irq_vector_out;
  bus_cfg_t bus_cfg_out;
  rx_dma_cfg_t rx_dma_cfg_out;
  logic [2:0] priority_level_out;
  logic tx_start_out, rx_resume_out, irq_req_out, rx_dma_req_out;
  logic rx_dma_mask_clear_out, rx_end_of_block_out, event_flags_clear_out;
  logic rd_q = 1'b0;
  note_t notes[$];
  int fail_count = 0;
  int checked = 0;
  logic [7:0] v, w, f5_val;
  logic [3:0] delays[4] = '{DELAY_2M5_6, DELAY_6_10, DELAY_10_14, DELAY_14_24};
  logic [15:0] rst_tab[11] = '{16'hf300, 16'hf400, 16'hf500, 16'hf600, 16'hf7a0, 16'hf8f0,
    16'hf900, 16'hfa00, 16'hfb00, 16'hfe00, 16'h8000};
  always #2.5 clk_in = ~clk_in;
  i2c_config_irq_dma_regs uut (.*);
  i2c_engine_model eng (.clk_in(clk_in), .err_flags_out(err_flags_in),
    .rx_byte_valid_out(rx_byte_valid_in), .rx_byte_out(rx_byte_in), .tx_ready_out(tx_ready_in),
    .rx_dma_done_out(rx_dma_done_in), .tx_dma_done_out(tx_dma_done_in),
    .rx_count_zero_out(rx_count_zero_in));
  // ==========================================================
  // tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic acc(input logic w_en, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_in <= '{wr: w_en, rd: !w_en, addr: a, wdata: d};
    if (!w_en) notes.push_back('{$sformatf("reg %h", a), {8'h00, d}});
  endtask : acc
  task automatic idle();
    @(posedge clk_in);
    req_in <= '0;
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
    idle();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, exp);
    idle();
  endtask : rd
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // ==========================================================
  // read-data monitor: one cycle after each read, oldest note
  always @(posedge clk_in) begin
    if (rd_q && notes.size() > 0) begin
      check(notes[0].name, {8'h00, rdata_out}, notes[0].v);
      void'(notes.pop_front());
    end
    rd_q <= req_in.rd;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    end_sim();
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h9733));
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    foreach (rst_tab[i]) acc(1'b0, rst_tab[i][15:8], rst_tab[i][7:0]);
    idle();
    check("prio", priority_level_out, 3'h7);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom());
      w = 8'($urandom());
      // range code kept legal, reserved bits kept clear
      f5_val = {i[1:0], v[5], 1'b0, 1'b0, v[2:1], 1'b0};
      wr(OFS_SCL_CLOCK_CONTROL, v);
      wr(OFS_EXT_CLOCK_CONTROL, {6'h00, w[1:0]});
      wr(OFS_OWN_ID_LOW, w);
      wr(OFS_OWN_ID_HIGH, f5_val);
      wr(OFS_GENERAL_CALL_ID, v ^ w);
      wr(OFS_RX_DMA_POINTER, v);
      wr(OFS_RX_DMA_COUNTER, w);
      rd(OFS_OWN_ID_HIGH, f5_val);
      repeat (2) @(posedge clk_in);
      check("fast", bus_cfg_out.fast_mode_select, v[7]);
      check("divider", bus_cfg_out.scl_divider, {w[1:0], v[6:0]});
      check("range", bus_cfg_out.clock_range_sel, i[2:0]);
      check("delay", bus_cfg_out.range_delay, delays[i]);
      check("own", bus_cfg_out.own_id, v[5] ? {v[2:1], w} : {3'h0, w[7:1]});
      check("gcall", bus_cfg_out.general_call, (v ^ w) >> 1);
      check("dma", rx_dma_cfg_out, {v, w});
    end
    wr(OFS_SCL_CLOCK_CONTROL, 8'h9d);
    wr(OFS_OWN_ID_HIGH, 8'hc0);
    wr(OFS_OWN_ID_LOW, 8'h01);
    wr(OFS_GENERAL_CALL_ID, 8'h01);
    repeat (2) @(posedge clk_in);
    check("own_valid", bus_cfg_out.own_id_valid, 1'b0);
    check("gc_valid", bus_cfg_out.general_call_valid, 1'b0);
    wr(OFS_GENERAL_CALL_ID, 8'h00);
    interface_enable_in <= 1'b1;
    wr(OFS_OWN_ID_HIGH, 8'h26);
    wr(OFS_GENERAL_CALL_ID, 8'h54);
    rd(OFS_OWN_ID_HIGH, 8'hc6);
    rd(OFS_GENERAL_CALL_ID, 8'h00);
    wr(OFS_DATA_BYTE, v);
    @(posedge clk_in);
    check("tx_byte", tx_byte_out, v);
    eng.pulse(0, w);
    rd(OFS_DATA_BYTE, w);
    eng.pulse(2, 8'h00);
    eng.pulse(3, 8'h00);
    rd(OFS_IRQ_PENDING, 8'hf0);
    wr(OFS_IRQ_VECTOR, 8'ha8);
    wr(OFS_IRQ_PENDING, 8'hb0);
    irq_global_enable_in <= 1'b1;
    eng.pulse(1, 8'h00);
    rd(OFS_IRQ_PENDING, 8'hb1);
    rd(OFS_IRQ_VECTOR, 8'hae);
    check("irq", irq_req_out, 1'b1);
    wr(OFS_IRQ_PENDING, 8'hb3);
    rd(OFS_IRQ_PENDING, 8'hb1);
    eng.pulse(0, v);
    rd(OFS_IRQ_VECTOR, 8'hac);
    eng.set_flags(err_flags_t'(8'h01 << ($urandom() % 8)));
    repeat (3) @(posedge clk_in);
    rd(OFS_IRQ_VECTOR, 8'haa);
    wr(OFS_IRQ_PENDING, 8'hb0);
    rd(OFS_IRQ_PENDING, 8'hb4);
    eng.set_flags('0);
    wr(OFS_IRQ_PENDING, 8'h30);
    rx_dma_mask_in <= 1'b1;
    eng.pulse(0, w);
    @(posedge clk_in);
    check("rx_dma_req", rx_dma_req_out, 1'b1);
    wr(OFS_IRQ_PENDING, 8'hf0);
    eng.pulse(1, 8'h00);
    repeat (3) @(posedge clk_in);
    check("irq_quiet", irq_req_out, 1'b0);
    rx_dma_mask_in <= 1'b1;
    eng.pulse(4, 8'h00);
    rx_dma_mask_in <= 1'b0;
    interface_enable_in <= 1'b0;
    wr(8'h80, 8'hff);
    rd(8'h80, 8'h00);
    rd(OFS_SCL_CLOCK_CONTROL, 8'h9d);
    repeat (4) @(posedge clk_in);
    end_sim();
  end
endmodule : i2c_config_irq_dma_regs_test
